// File: logic/shp_pkg.sv
package shp_pkg;
   // ---------------------------------------------------------------
   // Host side register map (AHB-Lite, word offsets)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] RDATA_OFS = 8'h0c;
   // CTRL fields
   localparam int CTRL_MUX = 0;
   localparam int CTRL_RST = 1;
   // CMD fields: [7:0] data, [8] write, [9] chan, [10] data_cmd,
   // [11] irq_acknowledge_n cycle, [15:12] register address
   localparam int CMD_WR = 8;
   localparam int CMD_CH = 9;
   localparam int CMD_DC = 10;
   localparam int CMD_ACK = 11;
   localparam int CMD_ADR = 12;
   // STAT fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_IRQ = 1;
   // ---------------------------------------------------------------
   // Device side control bits (per channel config byte)
   // ---------------------------------------------------------------
   localparam int CFG_DTR = 0;
   localparam int CFG_RTS = 1;
   localparam int CFG_AUTO = 2;
   localparam int CFG_ASYNC = 3;
   localparam int CFG_REQ = 4;
   localparam int CFG_WAITREQ = 5;
   localparam int CFG_XTAL = 6;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [1:0] RXMODE_ASYNC = 2'h0;
   localparam logic [1:0] RXMODE_EXT = 2'h1;
   localparam logic [1:0] RXMODE_INT = 2'h2;
   localparam logic [1:0] RXMODE_FLAG = 2'h3;
   localparam logic [7:0] VECTOR_DEF = 8'h00; // Arbitrary value
   // Clock factors 1/16/32/64 as shift amounts
   localparam logic [2:0] CLKF_X1 = 3'h0;
   localparam logic [2:0] CLKF_X16 = 3'h4;
   localparam logic [2:0] CLKF_X32 = 3'h5;
   localparam logic [2:0] CLKF_X64 = 3'h6;
   // Host strobe phase length in hclk cycles
   localparam int STROBE_NS = 48;
   localparam int CLK_NS = 8;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TX_MIN_DIV = 4;
   typedef enum logic [2:0] {
      SHP_IDLE = 3'b000,
      SHP_ADDR = 3'b001,
      SHP_STRB = 3'b010,
      SHP_DONE = 3'b011,
      SHP_RSTB = 3'b100
   } shp_state_e;
endpackage

// File: logic/shp_if.sv
`timescale 1ns/1ps
interface shp_if;
   logic [7:0] bus_host_d;
   logic bus_host_oe;
   logic [7:0] bus_dev_d;
   logic bus_dev_oe;
   logic chip_enable_n;
   logic channel_select;
   logic data_cmd_select;
   logic read_strobe_n;
   logic write_strobe_n;
   logic addr_strobe_n;
   logic data_strobe_n;
   logic chip_select_low;
   logic chip_select_high;
   logic rd_wr;
   logic irq_acknowledge_n;
   logic interrupt_enable_in;
   logic interrupt_enable_out;
   logic irq_out_oe;
   logic [1:0] terminal_ready_out;
   logic [1:0] send_request_out;
   logic [1:0] wait_req_d;
   logic [1:0] wait_req_oe;
   modport dev (
      input bus_host_d, bus_host_oe, chip_enable_n, channel_select,
      input data_cmd_select, read_strobe_n, write_strobe_n,
      input addr_strobe_n, data_strobe_n, chip_select_low,
      input chip_select_high, rd_wr, irq_acknowledge_n,
      input interrupt_enable_in,
      output bus_dev_d, bus_dev_oe, interrupt_enable_out, irq_out_oe,
      output terminal_ready_out, send_request_out, wait_req_d,
      output wait_req_oe
   );
   modport host (
      output bus_host_d, bus_host_oe, chip_enable_n, channel_select,
      output data_cmd_select, read_strobe_n, write_strobe_n,
      output addr_strobe_n, data_strobe_n, chip_select_low,
      output chip_select_high, rd_wr, irq_acknowledge_n,
      output interrupt_enable_in,
      input bus_dev_d, bus_dev_oe, interrupt_enable_out, irq_out_oe,
      input terminal_ready_out, send_request_out, wait_req_d,
      input wait_req_oe
   );
endinterface // shp_if

// File: logic/shp_dev.sv
`timescale 1ns/1ps
module shp_dev (
   input wire logic hclk,
   input wire logic hresetn,
   shp_if.dev pins,
   input wire logic [1:0] irq_pending,
   input wire logic [1:0] tx_empty,
   input wire logic [1:0] pattern_match,
   input wire logic [1:0] flag_seen,
   input wire logic [1:0] frame_align_in,
   input wire logic [1:0] rx_clk_edge,
   output logic [1:0] frame_align_out,
   output logic [1:0] frame_align_oe,
   output logic [1:0] hunt_status,
   output logic [1:0] assemble_start,
   output logic [1:0] tx_bit_tick,
   output logic [1:0] rx_sample_tick,
   output logic soft_reset
);
   // ---------------------------------------------------------------
   // Synchronisers: three stages, change once stages 2 and 3 agree
   // ---------------------------------------------------------------
   localparam int NS = 9;
   logic [NS-1:0] raw, s1_r, s2_r, s3_r, clean_r;
   assign raw = {pins.irq_acknowledge_n, pins.read_strobe_n,
      pins.write_strobe_n, pins.addr_strobe_n, pins.data_strobe_n,
      pins.chip_enable_n, pins.chip_select_high, frame_align_in};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= '1;
         s2_r <= '1;
         s3_r <= '1;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // Filter: accept a level only once two late stages agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clean_r <= '1;
      end else begin
         for (int i = 0; i < NS; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               clean_r[i] <= s3_r[i];
            end
         end
      end
   end
   logic ack_n, rd_n, wr_n, as_n, ds_n, ce_n, csh;
   logic [1:0] fa_s;
   assign {ack_n, rd_n, wr_n, as_n, ds_n, ce_n, csh, fa_s} = clean_r;

   // ---------------------------------------------------------------
   // Bus decode and reset coincidence
   // ---------------------------------------------------------------
   logic rst_np, rst_mx, rst_r;
   assign rst_np = !rd_n && !wr_n;
   assign rst_mx = !as_n && !ds_n;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_r <= 1'b0;
      end else begin
         rst_r <= rst_np || rst_mx;
      end
   end
   assign soft_reset = rst_r;

   // Muxed address latch on address strobe rising edge; bus held
   // from the synchronised fall, as it carries data by the rise
   logic as_d_r, csl_r, ds_d_r, wr_d_r, csl_hold_r;
   logic [7:0] maddr_r, adr_hold_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         as_d_r <= 1'b1;
         ds_d_r <= 1'b1;
         wr_d_r <= 1'b1;
         maddr_r <= 8'h00;
         csl_r <= 1'b0;
         adr_hold_r <= 8'h00;
         csl_hold_r <= 1'b0;
      end else begin
         as_d_r <= as_n;
         ds_d_r <= ds_n;
         wr_d_r <= wr_n;
         if (!as_n && as_d_r) begin
            adr_hold_r <= pins.bus_host_d;
            csl_hold_r <= !pins.chip_select_low;
         end
         if (as_n && !as_d_r) begin
            maddr_r <= adr_hold_r;
            csl_r <= csl_hold_r;
         end
      end
   end
   // Write strobes: nonmuxed on write rise, muxed on data rise
   logic np_wr, mx_wr;
   assign np_wr = wr_n && !wr_d_r && rd_n && !ce_n && ack_n;
   assign mx_wr = ds_n && !ds_d_r && as_n && csl_r && csh && !pins.rd_wr;
   // Channel config bytes and vector
   logic [7:0] cfg_r [2];
   logic [1:0] rxm_r [2];
   logic [2:0] clkf_r [2];
   logic [7:0] vec_r;
   localparam logic [7:0] CFG_RST_C = shp_pkg::CFG_RST;
   logic ch_np, ch_mx;
   assign ch_np = pins.channel_select;
   assign ch_mx = maddr_r[0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_r[0] <= CFG_RST_C;
         cfg_r[1] <= CFG_RST_C;
         rxm_r[0] <= shp_pkg::RXMODE_ASYNC;
         rxm_r[1] <= shp_pkg::RXMODE_ASYNC;
         clkf_r[0] <= shp_pkg::CLKF_X1;
         clkf_r[1] <= shp_pkg::CLKF_X1;
         vec_r <= shp_pkg::VECTOR_DEF;
      end else if (rst_r) begin
         cfg_r[0] <= CFG_RST_C;
         cfg_r[1] <= CFG_RST_C;
      end else if (np_wr && !pins.data_cmd_select) begin
         wreg(ch_np, pins.bus_host_d[7:6], pins.bus_host_d[5:0]);
      end else if (mx_wr && !maddr_r[1]) begin
         wreg(ch_mx, maddr_r[3:2], pins.bus_host_d[5:0]);
      end
   end
   // Command byte: [7:6] (muxed bus: address [3:2]) selects cfg, mode, clock factor or vector
   task automatic wreg(input logic ch, input logic [1:0] sel,
      input logic [5:0] v);
      case (sel)
         2'h0: cfg_r[ch] <= {2'b00, v};
         2'h1: rxm_r[ch] <= v[1:0];
         2'h2: clkf_r[ch] <= legal_clkf(v[2:0]);
         default: vec_r <= {2'b00, v};
      endcase
   endtask
   function automatic logic [2:0] legal_clkf(input logic [2:0] f);
      if (f == shp_pkg::CLKF_X16 || f == shp_pkg::CLKF_X32 ||
         f == shp_pkg::CLKF_X64) begin
         return f;
      end
      return shp_pkg::CLKF_X1;
   endfunction

   // ---------------------------------------------------------------
   // Interrupt daisy chain
   // ---------------------------------------------------------------
   logic ius_r, req;
   assign req = |irq_pending;
   // Under-service set by acknowledge when chain lets us win
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ius_r <= 1'b0;
      end else if (rst_r || !req) begin
         ius_r <= 1'b0;
      end else if (!ack_n && pins.interrupt_enable_in) begin
         ius_r <= 1'b1;
      end
   end
   assign pins.interrupt_enable_out = pins.interrupt_enable_in &&
      !ius_r && !(!ack_n && req);
   assign pins.irq_out_oe = req && pins.interrupt_enable_in && !ius_r;
   // Data bus: vector on acknowledge read, else channel status
   logic rd_sel, vec_rd;
   assign vec_rd = !ack_n && !rd_n && pins.interrupt_enable_in;
   assign rd_sel = (!rd_n && !ce_n && wr_n) ||
      (!ds_n && as_n && csl_r && csh && pins.rd_wr);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins.bus_dev_d <= 8'h00;
      end else if (vec_rd) begin
         pins.bus_dev_d <= vec_r;
      end else begin
         pins.bus_dev_d <= {4'h0, hunt_status, tx_empty};
      end
   end
   assign pins.bus_dev_oe = vec_rd || (rd_sel && ack_n);

   // ---------------------------------------------------------------
   // Per-channel modem pins, sync pin and rate ticks
   // ---------------------------------------------------------------
   logic [1:0] rts_r, hunt_r, fa_d_r;
   logic [1:0] txd_r [2];
   logic [6:0] rxc_r [2];
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic async, xt;
      assign async = rxm_r[c] == shp_pkg::RXMODE_ASYNC;
      assign xt = cfg_r[c][shp_pkg::CFG_XTAL];
      assign pins.terminal_ready_out[c] = cfg_r[c][shp_pkg::CFG_REQ] ?
         !tx_empty[c] : !cfg_r[c][shp_pkg::CFG_DTR];
      // Auto release: hold low until transmitter drained
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rts_r[c] <= 1'b1;
         end else if (cfg_r[c][shp_pkg::CFG_RTS]) begin
            rts_r[c] <= 1'b0;
         end else if (!(cfg_r[c][shp_pkg::CFG_ASYNC] &&
            cfg_r[c][shp_pkg::CFG_AUTO]) || tx_empty[c]) begin
            rts_r[c] <= 1'b1;
         end
      end
      assign pins.send_request_out[c] = rts_r[c];
      // Wait is open drain, request drives both levels
      assign pins.wait_req_d[c] = cfg_r[c][shp_pkg::CFG_WAITREQ] ?
         !tx_empty[c] : 1'b0;
      assign pins.wait_req_oe[c] = cfg_r[c][shp_pkg::CFG_WAITREQ] ||
         (!tx_empty[c] && !ce_n);
      // Sync pin input updates hunt status only in async mode with xtal off
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            hunt_r[c] <= 1'b1;
            fa_d_r[c] <= 1'b1;
         end else begin
            fa_d_r[c] <= fa_s[c];
            if (async && !xt) begin
               hunt_r[c] <= fa_s[c];
            end
         end
      end
      assign hunt_status[c] = hunt_r[c];
      // Pin falls before the clock edge that starts the character
      assign assemble_start[c] = rxm_r[c] == shp_pkg::RXMODE_EXT &&
         !xt && !fa_s[c] && fa_d_r[c];
      assign frame_align_oe[c] = !xt &&
         (rxm_r[c] == shp_pkg::RXMODE_INT ||
          rxm_r[c] == shp_pkg::RXMODE_FLAG);
      assign frame_align_out[c] = !((rxm_r[c] == shp_pkg::RXMODE_INT &&
         pattern_match[c]) ||
         (rxm_r[c] == shp_pkg::RXMODE_FLAG && flag_seen[c]));
      // Transmit tick never faster than a quarter of clock
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            txd_r[c] <= 2'h0;
         end else begin
            txd_r[c] <= txd_r[c] + 2'h1;
         end
      end
      assign tx_bit_tick[c] = txd_r[c] == 2'(shp_pkg::TX_MIN_DIV - 1);
      // Receive clock divided by the selected factor
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            rxc_r[c] <= 7'h00;
         end else if (rx_clk_edge[c]) begin
            rxc_r[c] <= (rxc_r[c] + 7'h01) &
               7'((8'h01 << clkf_r[c]) - 8'h01);
         end
      end
      assign rx_sample_tick[c] = rx_clk_edge[c] && rxc_r[c] == 7'h00;
   end
endmodule // shp_dev

// File: logic/shp_host.sv
`timescale 1ns/1ps
module shp_host (
   input wire logic hclk,
   input wire logic hresetn,
   shp_if.host pins,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic upstream_enable
);
   // ---------------------------------------------------------------
   // AHB-Lite slave: CTRL, CMD (starts a cycle), STAT, RDATA
   // ---------------------------------------------------------------
   logic wr_pend_r, rd_pend_r;
   logic [7:0] addr_r;
   logic [1:0] ctrl_r;
   logic [15:0] cmd_r;
   logic [7:0] rdata_r;
   logic busy;
   shp_pkg::shp_state_e st_r;
   logic [3:0] cnt_r;
   assign busy = st_r != shp_pkg::SHP_IDLE;
   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= hsel && htrans[1] && hwrite;
         rd_pend_r <= hsel && htrans[1] && !hwrite;
         addr_r <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   logic go;
   assign go = wr_pend_r && addr_r == shp_pkg::CMD_OFS && !busy;
   // Register writes; busy command writes are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= 2'h0;
         cmd_r <= 16'h0000;
      end else if (wr_pend_r && addr_r == shp_pkg::CTRL_OFS) begin
         ctrl_r <= hwdata[1:0];
      end else if (go) begin
         cmd_r <= hwdata[15:0];
      end
   end
   always_comb begin
      hrdata = 32'h0;
      case (addr_r)
         shp_pkg::CTRL_OFS: hrdata = {30'h0, ctrl_r};
         shp_pkg::CMD_OFS: hrdata = {16'h0, cmd_r};
         shp_pkg::STAT_OFS: hrdata = {30'h0, pins.irq_out_oe, busy};
         shp_pkg::RDATA_OFS: hrdata = {24'h0, rdata_r};
         default: hrdata = 32'h0;
      endcase
   end
   logic unused;
   assign unused = rd_pend_r ^ (|hsize) ^ (|haddr[31:8]);

   // ---------------------------------------------------------------
   // Pin sequencer: address, strobe, recovery
   // ---------------------------------------------------------------
   logic mux, strb, rst_cmd;
   assign mux = ctrl_r[shp_pkg::CTRL_MUX];
   assign rst_cmd = ctrl_r[shp_pkg::CTRL_RST];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= shp_pkg::SHP_IDLE;
         cnt_r <= 4'h0;
      end else begin
         case (st_r)
            shp_pkg::SHP_IDLE: begin
               cnt_r <= 4'h0;
               if (go) begin
                  st_r <= mux ? shp_pkg::SHP_ADDR : shp_pkg::SHP_STRB;
               end
            end
            shp_pkg::SHP_ADDR, shp_pkg::SHP_STRB, shp_pkg::SHP_DONE: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(shp_pkg::STROBE_CYC - 1)) begin
                  cnt_r <= 4'h0;
                  st_r <= st_r == shp_pkg::SHP_ADDR ? shp_pkg::SHP_STRB :
                     st_r == shp_pkg::SHP_STRB ? shp_pkg::SHP_DONE :
                     shp_pkg::SHP_IDLE;
               end
            end
            default: st_r <= shp_pkg::SHP_IDLE;
         endcase
      end
   end
   assign strb = st_r == shp_pkg::SHP_STRB;
   logic wr;
   assign wr = cmd_r[shp_pkg::CMD_WR];
   // Capture read data at end of strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 8'h00;
      end else if (strb && pins.bus_dev_oe &&
         cnt_r == 4'(shp_pkg::STROBE_CYC - 1)) begin
         rdata_r <= pins.bus_dev_d;
      end
   end
   logic ack;
   assign ack = cmd_r[shp_pkg::CMD_ACK];
   assign pins.irq_acknowledge_n = !(busy && ack);
   assign pins.interrupt_enable_in = upstream_enable;
   assign pins.chip_enable_n = !(!mux && busy && !ack);
   assign pins.channel_select = cmd_r[shp_pkg::CMD_CH];
   assign pins.data_cmd_select = cmd_r[shp_pkg::CMD_DC];
   assign pins.read_strobe_n = !((strb && !wr && !mux) || rst_cmd);
   assign pins.write_strobe_n = !((strb && wr && !mux && !ack) ||
      (rst_cmd && !mux));
   assign pins.addr_strobe_n = !((st_r == shp_pkg::SHP_ADDR) ||
      (rst_cmd && mux));
   assign pins.data_strobe_n = !((strb && mux) || (rst_cmd && mux));
   assign pins.chip_select_low = !(mux && busy);
   assign pins.chip_select_high = mux && (busy || rst_cmd);
   assign pins.rd_wr = !wr;
   assign pins.bus_host_d = st_r == shp_pkg::SHP_ADDR ?
      {4'h0, cmd_r[15:12]} : cmd_r[7:0];
   assign pins.bus_host_oe = (st_r == shp_pkg::SHP_ADDR) || (strb && wr);
endmodule // shp_host

// File: sim/shp_properties.sv
`timescale 1ns/1ps
module shp_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic bus_host_oe,
   input wire logic bus_dev_oe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic addr_strobe_n,
   input wire logic data_strobe_n,
   input wire logic chip_select_high,
   input wire logic irq_acknowledge_n,
   input wire logic interrupt_enable_in,
   input wire logic interrupt_enable_out,
   input wire logic irq_out_oe,
   input wire logic [1:0] terminal_ready_out,
   input wire logic [1:0] send_request_out,
   input wire logic [1:0] wait_req_oe
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ---------------------------------------------------------------
   // Pin relations across both ends
   // ---------------------------------------------------------------
   a_ieo_needs_iei: assert property (
      !interrupt_enable_in [*2] |-> !interrupt_enable_out)
      else $error("enable out high while enable in low");
   a_ieo_ack_req: assert property (
      (!irq_acknowledge_n && irq_out_oe) [*5] |-> !interrupt_enable_out)
      else $error("enable out high while acknowledging a request");
   a_bus_no_clash: assert property (
      !(bus_host_oe && bus_dev_oe))
      else $error("both ends drive the data bus");
   a_dev_drive_rd: assert property (
      (read_strobe_n && data_strobe_n) [*6] |-> !bus_dev_oe)
      else $error("device drives bus without a read");
   a_pin_defaults: assert property (
      $rose(hresetn) |-> terminal_ready_out == 2'h3
         && send_request_out == 2'h3 && !irq_out_oe)
      else $error("modem or irq pins wrong after reset");
   a_wait_reset: assert property (
      $rose(hresetn) |-> wait_req_oe == 2'h0)
      else $error("wait pin driven after reset");
   a_rdwr_reset: assert property (
      (!read_strobe_n && !write_strobe_n) [*6]
         |-> ##[1:8] terminal_ready_out == 2'h3)
      else $error("read write coincidence did not reset");
   a_asds_reset: assert property (
      (!addr_strobe_n && !data_strobe_n) [*6]
         |-> ##[1:8] terminal_ready_out == 2'h3)
      else $error("address data coincidence did not reset");
   a_cs1_held: assert property (
      (!addr_strobe_n || !data_strobe_n) |-> chip_select_high)
      else $error("high chip select dropped in access");
endmodule // shp_properties

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, chk_ph, up_en;
   logic [31:0] haddr, hwdata, hrdata, seed_v;
   logic [1:0] htrans, irq_pending, tx_empty;
   logic [2:0] hsize;
   logic [5:0] v;
   logic [3:0] ra;
   logic [1:0] fa_in, asm;
   logic asm_seen = 1'b0;
   logic [31:0] exp_q[$], msk_q[$];
   int failures = 0;
   int total_checks = 0;
   shp_if pins_if ();
   shp_dev shp_dev_i (.hclk(hclk), .hresetn(hresetn), .pins(pins_if),
      .irq_pending(irq_pending), .tx_empty(tx_empty),
      .pattern_match(2'h0), .flag_seen(2'h0), .frame_align_in(fa_in),
      .rx_clk_edge(2'h0), .frame_align_out(), .frame_align_oe(),
      .hunt_status(), .assemble_start(asm), .tx_bit_tick(),
      .rx_sample_tick(), .soft_reset());
   shp_host shp_host_i (.hclk(hclk), .hresetn(hresetn), .pins(pins_if),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .upstream_enable(up_en));
   shp_properties shp_properties_i (.hclk(hclk), .hresetn(hresetn),
      .bus_host_oe(pins_if.bus_host_oe), .bus_dev_oe(pins_if.bus_dev_oe),
      .read_strobe_n(pins_if.read_strobe_n),
      .write_strobe_n(pins_if.write_strobe_n),
      .addr_strobe_n(pins_if.addr_strobe_n),
      .data_strobe_n(pins_if.data_strobe_n),
      .chip_select_high(pins_if.chip_select_high),
      .irq_acknowledge_n(pins_if.irq_acknowledge_n),
      .interrupt_enable_in(pins_if.interrupt_enable_in),
      .interrupt_enable_out(pins_if.interrupt_enable_out),
      .irq_out_oe(pins_if.irq_out_oe),
      .terminal_ready_out(pins_if.terminal_ready_out),
      .send_request_out(pins_if.send_request_out),
      .wait_req_oe(pins_if.wait_req_oe));
   // ---------------------------------------------------------------
   // Clock, checks and bus tasks
   // ---------------------------------------------------------------
   initial hclk = 1'b0;
   always #4 hclk = ~hclk;
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t read %h expected %h", $time, g, e);
      end
   endtask
   // Sampled mid-cycle so register updates have landed
   task automatic cmp_pin(input logic [1:0] g, input logic [1:0] e);
      @(negedge hclk);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t pins %b expected %b", $time, g, e);
      end
      @(posedge hclk);
   endtask
   // One single word transfer; zero wait states are not assumed
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic c, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      chk_ph <= c;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      chk_ph <= 1'b0;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      logic [31:0] q;
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      ahb(1'b0, a, 32'h0, 1'b1, q);
   endtask
   // Poll busy before the next pin cycle; polling gives up after 200 reads
   task automatic idle;
      logic [31:0] q;
      q = 32'h1;
      for (int i = 0; i < 200 && q[0] !== 1'b0; i++)
         ahb(1'b0, shp_pkg::STAT_OFS, 32'h0, 1'b0, q);
      repeat (8) @(posedge hclk);
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      idle();
      ahb(1'b1, a, d, 1'b0, q);
      idle();
   endtask
   function automatic logic [31:0] mk(logic [3:0] a, logic k, logic d,
      logic c, logic w, logic [7:0] b);
      return {16'h0, a, k, d, c, w, b};
   endfunction
   // Result watcher pairs each read answer with the oldest note
   always @(posedge hclk) begin
      if (chk_ph === 1'b1 && hreadyout === 1'b1 && exp_q.size() > 0)
         cmp_word(hrdata & msk_q.pop_front(), exp_q.pop_front());
   end
   // Sticky copy of the one-cycle assembly start pulse
   always @(posedge hclk) begin
      if (asm[0] === 1'b1) asm_seen <= 1'b1;
   end
   initial begin
      #400000;
      failures++;
      wrap_up();
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, chk_ph, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      up_en = 1'b1;
      irq_pending = 2'h0;
      tx_empty = 2'h3;
      fa_in = 2'h3;
      seed_v = $urandom(32'hd7ed);
      v = 6'($urandom());
      ra = 4'($urandom());
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_exp(shp_pkg::STAT_OFS, 32'h0, 32'h3);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, 8'h01));
      cmp_pin(pins_if.terminal_ready_out, 2'h2);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 1, 1, 1, 8'h01));
      cmp_pin(pins_if.terminal_ready_out, 2'h2);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, 8'h03));
      cmp_pin(pins_if.send_request_out, 2'h2);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, 8'h01));
      cmp_pin(pins_if.send_request_out, 2'h3);
      // Async auto enable: release waits for an empty transmitter
      tx_empty <= 2'h2;
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, 8'h0e));
      cmp_pin(pins_if.send_request_out, 2'h2);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, 8'h0c));
      cmp_pin(pins_if.send_request_out, 2'h2);
      tx_empty <= 2'h3;
      repeat (8) @(posedge hclk);
      cmp_pin(pins_if.send_request_out, 2'h3);
      // Vector, request and acknowledge cycle
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 0, 1, {2'h3, v}));
      irq_pending <= 2'h1;
      repeat (8) @(posedge hclk);
      cmp_pin({1'b0, pins_if.irq_out_oe}, 2'h1);
      rd_exp(shp_pkg::STAT_OFS, 32'h2, 32'h3);
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 1, 0, 0, 0, 8'h00));
      rd_exp(shp_pkg::RDATA_OFS, {26'h0, v}, 32'h3f);
      up_en <= 1'b0;
      repeat (8) @(posedge hclk);
      cmp_pin({1'b0, pins_if.interrupt_enable_out}, 2'h0);
      up_en <= 1'b1;
      irq_pending <= 2'h0;
      repeat (8) @(posedge hclk);
      cmp_pin({1'b0, pins_if.interrupt_enable_out}, 2'h1);
      // Strobe coincidence resets, plain then multiplexed bus
      wreg(shp_pkg::CMD_OFS, mk(4'h0, 0, 0, 1, 1, 8'h01));
      cmp_pin(pins_if.terminal_ready_out, 2'h1);
      wreg(shp_pkg::CTRL_OFS, 32'h2);
      wreg(shp_pkg::CTRL_OFS, 32'h0);
      cmp_pin(pins_if.terminal_ready_out, 2'h3);
      wreg(shp_pkg::CTRL_OFS, 32'h1);
      wreg(shp_pkg::CMD_OFS, mk({3'h0, ra[0]}, 0, 0, 1, 1, 8'h01));
      cmp_pin(pins_if.terminal_ready_out, {~ra[0], ra[0]});
      wreg(shp_pkg::CTRL_OFS, 32'h3);
      wreg(shp_pkg::CTRL_OFS, 32'h1);
      cmp_pin(pins_if.terminal_ready_out, 2'h3);
      // External sync on channel 0: frame pin fall starts the character
      wreg(shp_pkg::CMD_OFS, mk(4'h4, 0, 0, 0, 1, 8'h01));
      fa_in <= 2'h2;
      repeat (8) @(posedge hclk);
      fa_in <= 2'h3;
      repeat (8) @(posedge hclk);
      cmp_pin({1'b0, asm_seen}, 2'h1);
      wrap_up();
   end
endmodule // testbench
